// ---- src/dt_pkg.sv ----
// types shared by the dual timer modules
// assumes nothing of its surroundings
package dt_pkg;
   typedef logic [7:0] dt_byte_t;
   typedef enum logic [1:0] {
      DT_MODE_13BIT,
      DT_MODE_16BIT,
      DT_MODE_RELOAD,
      DT_MODE_SPLIT
   } dt_mode_e;
endpackage

// ---- src/dt_prescaler.sv ----
// prescaler: one-cycle tick every N system clocks, N from the scale bits
// assumes scale bits come from logic on the same clock
`include "dt_timer_params.svh"
module dt_prescaler (
   // clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   // scale select
   input  wire logic [1:0] scale_in,
   // prescaled tick
   output logic            tick_out
);
   logic [5:0] cnt_reg;
   logic [5:0] cnt_next;
   logic [5:0] limit;
   logic       wrap;

   assign limit = (scale_in == 2'd0) ? `DT_DIV_SCALE0 :
                  (scale_in == 2'd1) ? `DT_DIV_SCALE1 :
                  (scale_in == 2'd2) ? `DT_DIV_SCALE2 : `DT_DIV_SCALE3;
   assign wrap     = (cnt_reg >= limit - 6'd1);
   assign cnt_next = wrap ? 6'd0 : cnt_reg + 6'd1;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_reg  <= 6'd0;
         tick_out <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_out <= wrap;
      end
   end
endmodule

// ---- src/dt_sync.sv ----
// two-flop synchroniser for the four timer pins, with falling-edge pulses
// assumes pins are asynchronous to sys_clk_in
module dt_sync (
   // clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   // pins
   input  wire logic [3:0] pin_in,
   // synchronised levels and falling edges
   output logic      [3:0] level_out,
   output logic      [3:0] fall_out
);
   logic [3:0] stage1_reg;
   logic [3:0] stage2_reg;
   logic [3:0] stage3_reg;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage1_reg <= 4'hF;
         stage2_reg <= 4'hF;
         stage3_reg <= 4'hF;
      end else begin
         stage1_reg <= pin_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   assign level_out = stage2_reg;
   assign fall_out  = stage3_reg & ~stage2_reg;
endmodule

// ---- src/dt_timer.sv ----
// dual 16-bit timer with four modes, reached through byte registers
// assumes a byte register port on sys_clk_in, pins asynchronous
//
// Behaviour
// RQ1 - each timer count is 16 bits, read and written as low and high byte
// RQ2 - each timer has its own mode bits selecting one of four modes
// RQ3 - timer interrupt forwarded only while its enable bit is set
// RQ4 - 13-bit mode: high byte upper eight bits, low bits 4..0 lower five
// RQ5 - 13-bit wrap from 0x1FFF to zero sets overflow flag
// RQ6 - counts while run set and gate clear or external input low
// RQ7 - setting run keeps the count as it is
// RQ8 - timer 1 mirrors timer 0 in modes 0..2 with its own bits
// RQ9 - 16-bit mode wraps all ones to zero and sets overflow flag
// RQ10 - reload mode: low byte counts, wrap reloads from unchanged high byte
// RQ11 - software loads low byte before starting reload mode
// RQ12 - split mode: timer 0 low byte uses timer 0 run, select, gate, flag
// RQ13 - split low byte counts system ticks or external pin by select bit
// RQ14 - split high byte is a timer only, run by timer 1 run bit
// RQ15 - split high byte overflow sets timer 1 flag
// RQ16 - during split, timer 1 overflow leaves its flag, feeds baud tick
// RQ17 - during split, timer 1 runs in modes 0..2, stops in mode 3
// RQ18 - flags set by hardware, cleared by software or interrupt vector
// RQ19 - control register bit layout, reset 00001010, bit addressable
// RQ20 - count clock is system clock or prescaled clock per select bits
// RQ21 - enabled timer adds one per tick, holds while disabled
`include "dt_timer_params.svh"
module dt_timer (
   // clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             rst_n_in,
   // register port
   input  wire logic [7:0]       sfr_addr_in,
   input  wire logic             sfr_wr_in,
   input  wire dt_pkg::dt_byte_t sfr_wdata_in,
   input  wire logic             sfr_bit_wr_in,
   input  wire logic [2:0]       sfr_bit_idx_in,
   input  wire logic             sfr_bit_val_in,
   output dt_pkg::dt_byte_t      sfr_rdata_out,
   // pins
   input  wire logic             ext_irq_in_a_n_in,
   input  wire logic             ext_irq_in_b_n_in,
   input  wire logic             t0_count_pin_in,
   input  wire logic             t1_count_pin_in,
   // interrupt vector acknowledge
   input  wire logic             t0_irq_ack_in,
   input  wire logic             t1_irq_ack_in,
   // interrupt requests and baud tick
   output logic                  t0_irq_out,
   output logic                  t1_irq_out,
   output logic                  t1_baud_tick_out
);
   import dt_pkg::*;

   // registers
   dt_byte_t   t0_count_low_reg;
   dt_byte_t   t0_count_high_reg;
   dt_byte_t   t1_count_low_reg;
   dt_byte_t   t1_count_high_reg;
   dt_byte_t   timer_mode_select_reg;
   dt_byte_t   clock_ctrl_reg;
   dt_byte_t   interrupt_enable_reg;
   logic       t0_overflow_flag_reg;
   logic       t1_overflow_flag_reg;
   logic       t0_run_reg;
   logic       t1_run_reg;
   logic [3:0] ext_ctrl_reg;

   dt_byte_t   t0_count_low_next;
   dt_byte_t   t0_count_high_next;
   dt_byte_t   t1_count_low_next;
   dt_byte_t   t1_count_high_next;
   logic       t0_overflow_flag_next;
   logic       t1_overflow_flag_next;
   dt_byte_t   ctrl_cur;
   dt_byte_t   ctrl_sw;
   dt_byte_t   rdata_next;

   // one counting step for modes 0..2; split mode steps the low byte only
   function automatic logic [16:0] dt_step(input dt_mode_e mode, input dt_byte_t lo, input dt_byte_t hi);
      logic [12:0] c13;
      logic [15:0] c16;
      logic [16:0] res;
      c13 = {hi, lo[4:0]} + 13'd1;
      c16 = {hi, lo} + 16'd1;
      case (mode)
         DT_MODE_13BIT: begin
            res = {(c13 == 13'd0), c13[12:5], lo[7:5], c13[4:0]}; // RQ4 RQ5
         end
         DT_MODE_16BIT: begin
            res = {(c16 == 16'd0), c16[15:8], c16[7:0]}; // RQ9
         end
         DT_MODE_RELOAD: begin
            if (lo == 8'hFF) begin
               res = {1'b1, hi, hi}; // RQ10
            end else begin
               res = {1'b0, hi, lo + 8'd1};
            end
         end
         default: begin
            res = {(lo == 8'hFF), hi, lo + 8'd1};
         end
      endcase
      return res;
   endfunction

   // pin synchronisers
   logic [3:0] pin_level;
   logic [3:0] pin_fall;

   dt_sync u_sync (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .pin_in     ({t1_count_pin_in, t0_count_pin_in, ext_irq_in_b_n_in, ext_irq_in_a_n_in}),
      .level_out  (pin_level),
      .fall_out   (pin_fall)
   );

   // prescaled clock
   logic presc_tick;

   dt_prescaler u_presc (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .scale_in   (clock_ctrl_reg[1:0]),
      .tick_out   (presc_tick)
   );

   // mode decode
   dt_mode_e t0_mode;
   dt_mode_e t1_mode;
   logic     t0_split;
   assign t0_mode  = dt_mode_e'(timer_mode_select_reg[1:0]); // RQ2
   assign t1_mode  = dt_mode_e'(timer_mode_select_reg[5:4]); // RQ2
   assign t0_split = (t0_mode == DT_MODE_SPLIT);

   // tick selection
   logic t0_timer_tick;
   logic t1_timer_tick;
   logic t0_tick;
   logic t1_tick;
   assign t0_timer_tick = timer_mode_select_reg[`DT_CT0_BIT] ? 1'b0 :
                          (clock_ctrl_reg[`DT_T0_CLKSEL_BIT] ? 1'b1 : presc_tick); // RQ20
   assign t1_timer_tick = clock_ctrl_reg[`DT_T1_CLKSEL_BIT] ? 1'b1 : presc_tick; // RQ20
   assign t0_tick = timer_mode_select_reg[`DT_CT0_BIT] ? pin_fall[2] : t0_timer_tick; // RQ13
   assign t1_tick = timer_mode_select_reg[`DT_CT1_BIT] ? pin_fall[3] : t1_timer_tick;

   // run qualification; external input active while pin low
   logic t0_run_ok;
   logic t1_run_ok;
   logic t0_en;
   logic t1_en;
   logic t0_high_en;
   assign t0_run_ok = t0_run_reg & (~timer_mode_select_reg[`DT_T0_GATE_ENABLE_BIT] | ~pin_level[0]); // RQ6 RQ12
   assign t1_run_ok = (t0_split ? 1'b1 : t1_run_reg)
                      & (~timer_mode_select_reg[`DT_GATE1_BIT] | ~pin_level[1])
                      & (t1_mode != DT_MODE_SPLIT); // RQ8 RQ17
   assign t0_en      = t0_run_ok & t0_tick; // RQ21
   assign t1_en      = t1_run_ok & t1_tick; // RQ21
   assign t0_high_en = t0_split & t1_run_reg & t1_timer_tick; // RQ14

   // counting steps
   logic [16:0] t0_step;
   logic [16:0] t1_step;
   logic        t0_ovf;
   logic        t1_ovf;
   logic        t0_high_ovf;
   assign t0_step     = dt_step(t0_mode, t0_count_low_reg, t0_count_high_reg);
   assign t1_step     = dt_step(t1_mode, t1_count_low_reg, t1_count_high_reg); // RQ8
   assign t0_ovf      = t0_en & t0_step[16];
   assign t1_ovf      = t1_en & t1_step[16];
   assign t0_high_ovf = t0_high_en & (t0_count_high_reg == 8'hFF);

   // write decode
   logic wr_ctrl;
   logic bit_wr_ctrl;
   logic wr_mode;
   logic wr_t0_low;
   logic wr_t0_high;
   logic wr_t1_low;
   logic wr_t1_high;
   logic wr_clk;
   logic wr_ie;
   assign wr_ctrl     = sfr_wr_in & (sfr_addr_in == `DT_ADDR_CONTROL);
   assign bit_wr_ctrl = sfr_bit_wr_in & (sfr_addr_in == `DT_ADDR_CONTROL); // RQ19
   assign wr_mode     = sfr_wr_in & (sfr_addr_in == `DT_ADDR_MODE);
   assign wr_t0_low   = sfr_wr_in & (sfr_addr_in == `DT_ADDR_T0_LOW); // RQ1
   assign wr_t0_high  = sfr_wr_in & (sfr_addr_in == `DT_ADDR_T0_HIGH); // RQ1
   assign wr_t1_low   = sfr_wr_in & (sfr_addr_in == `DT_ADDR_T1_LOW); // RQ1
   assign wr_t1_high  = sfr_wr_in & (sfr_addr_in == `DT_ADDR_T1_HIGH); // RQ1
   assign wr_clk      = sfr_wr_in & (sfr_addr_in == `DT_ADDR_CLOCK_CTRL);
   assign wr_ie       = sfr_wr_in & (sfr_addr_in == `DT_ADDR_IRQ_ENABLE);

   // control register view and software update, byte or single bit
   assign ctrl_cur = {t1_overflow_flag_reg, t1_run_reg, t0_overflow_flag_reg, t0_run_reg, ext_ctrl_reg}; // RQ19

   always_comb begin
      ctrl_sw = ctrl_cur;
      if (wr_ctrl) begin
         ctrl_sw = sfr_wdata_in;
      end else if (bit_wr_ctrl) begin
         ctrl_sw[sfr_bit_idx_in] = sfr_bit_val_in; // RQ19
      end
   end

   // flags: hardware set wins over software or vector clear
   assign t0_overflow_flag_next = t0_ovf
                                  | (ctrl_sw[`DT_TF0_BIT] & ~t0_irq_ack_in); // RQ5 RQ9 RQ10 RQ12 RQ18
   assign t1_overflow_flag_next = (t0_split ? t0_high_ovf : t1_ovf)
                                  | (ctrl_sw[`DT_TF1_BIT] & ~t1_irq_ack_in); // RQ15 RQ16 RQ18

   // count bytes: software write wins over the step in that byte
   always_comb begin
      t0_count_low_next = t0_count_low_reg;
      if (wr_t0_low) begin
         t0_count_low_next = sfr_wdata_in;
      end else if (t0_en) begin
         t0_count_low_next = t0_step[7:0]; // RQ21
      end
   end

   always_comb begin
      t0_count_high_next = t0_count_high_reg;
      if (wr_t0_high) begin
         t0_count_high_next = sfr_wdata_in;
      end else if (t0_high_en) begin
         t0_count_high_next = t0_count_high_reg + 8'd1; // RQ14
      end else if (t0_en && !t0_split) begin
         t0_count_high_next = t0_step[15:8];
      end
   end

   always_comb begin
      t1_count_low_next = t1_count_low_reg;
      if (wr_t1_low) begin
         t1_count_low_next = sfr_wdata_in;
      end else if (t1_en) begin
         t1_count_low_next = t1_step[7:0]; // RQ8
      end
   end

   always_comb begin
      t1_count_high_next = t1_count_high_reg;
      if (wr_t1_high) begin
         t1_count_high_next = sfr_wdata_in;
      end else if (t1_en) begin
         t1_count_high_next = t1_step[15:8]; // RQ8
      end
   end

   // read mux
   always_comb begin
      if (sfr_addr_in == `DT_ADDR_CONTROL) begin
         rdata_next = ctrl_cur;
      end else if (sfr_addr_in == `DT_ADDR_MODE) begin
         rdata_next = timer_mode_select_reg;
      end else if (sfr_addr_in == `DT_ADDR_T0_LOW) begin
         rdata_next = t0_count_low_reg;
      end else if (sfr_addr_in == `DT_ADDR_T0_HIGH) begin
         rdata_next = t0_count_high_reg;
      end else if (sfr_addr_in == `DT_ADDR_T1_LOW) begin
         rdata_next = t1_count_low_reg;
      end else if (sfr_addr_in == `DT_ADDR_T1_HIGH) begin
         rdata_next = t1_count_high_reg;
      end else if (sfr_addr_in == `DT_ADDR_CLOCK_CTRL) begin
         rdata_next = clock_ctrl_reg;
      end else if (sfr_addr_in == `DT_ADDR_IRQ_ENABLE) begin
         rdata_next = interrupt_enable_reg;
      end else begin
         rdata_next = `DT_RST_ZERO;
      end
   end

   // configuration registers
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         timer_mode_select_reg <= `DT_RST_ZERO;
         clock_ctrl_reg        <= `DT_RST_ZERO;
         interrupt_enable_reg  <= `DT_RST_ZERO;
      end else begin
         if (wr_mode) begin
            timer_mode_select_reg <= sfr_wdata_in;
         end
         if (wr_clk) begin
            clock_ctrl_reg <= sfr_wdata_in;
         end
         if (wr_ie) begin
            interrupt_enable_reg <= sfr_wdata_in;
         end
      end
   end

   // control register; run bits never touch the counts
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {t1_overflow_flag_reg, t1_run_reg, t0_overflow_flag_reg, t0_run_reg, ext_ctrl_reg} <= `DT_RST_CONTROL;
      end else begin
         t1_overflow_flag_reg <= t1_overflow_flag_next;
         t0_overflow_flag_reg <= t0_overflow_flag_next;
         t1_run_reg           <= ctrl_sw[`DT_TR1_BIT]; // RQ7
         t0_run_reg           <= ctrl_sw[`DT_TR0_BIT]; // RQ7
         ext_ctrl_reg         <= ctrl_sw[3:0];
      end
   end

   // count registers
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         t0_count_low_reg  <= `DT_RST_ZERO;
         t0_count_high_reg <= `DT_RST_ZERO;
         t1_count_low_reg  <= `DT_RST_ZERO;
         t1_count_high_reg <= `DT_RST_ZERO;
      end else begin
         t0_count_low_reg  <= t0_count_low_next;
         t0_count_high_reg <= t0_count_high_next;
         t1_count_low_reg  <= t1_count_low_next;
         t1_count_high_reg <= t1_count_high_next;
      end
   end

   // outputs
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sfr_rdata_out    <= `DT_RST_ZERO;
         t1_baud_tick_out <= 1'b0;
      end else begin
         sfr_rdata_out    <= rdata_next;
         t1_baud_tick_out <= t1_ovf; // RQ16
      end
   end

   assign t0_irq_out = t0_overflow_flag_reg & interrupt_enable_reg[`DT_ET0_BIT]; // RQ3
   assign t1_irq_out = t1_overflow_flag_reg & interrupt_enable_reg[`DT_ET1_BIT]; // RQ3
endmodule

// ---- src/dt_timer_params.svh ----
// constants of the dual timer: register addresses, field positions,
// reset values and prescaler divide counts; definitions only
`ifndef DT_TIMER_PARAMS_SVH
`define DT_TIMER_PARAMS_SVH

// register addresses
`define DT_ADDR_CONTROL     8'h88
`define DT_ADDR_MODE        8'h89
`define DT_ADDR_T0_LOW      8'h8A
`define DT_ADDR_T1_LOW      8'h8B
`define DT_ADDR_T0_HIGH     8'h8C
`define DT_ADDR_T1_HIGH     8'h8D
`define DT_ADDR_CLOCK_CTRL  8'h8E
`define DT_ADDR_IRQ_ENABLE  8'hA8

// reset values
`define DT_RST_CONTROL      8'h0A
`define DT_RST_ZERO         8'h00

// control register fields
`define DT_TF1_BIT          7
`define DT_TR1_BIT          6
`define DT_TF0_BIT          5
`define DT_TR0_BIT          4

// mode register fields
`define DT_GATE1_BIT        7
`define DT_CT1_BIT          6
`define DT_T0_GATE_ENABLE_BIT        3
`define DT_CT0_BIT          2

// clock control fields
`define DT_T1_CLKSEL_BIT    3
`define DT_T0_CLKSEL_BIT    2

// interrupt enable fields
`define DT_ET1_BIT          3
`define DT_ET0_BIT          1

// prescaler divide counts per clock scale code
`define DT_DIV_SCALE0       6'd12
`define DT_DIV_SCALE1       6'd4
`define DT_DIV_SCALE2       6'd48
`define DT_DIV_SCALE3       6'd8

`endif

// ---- verification/dt_timer_monitor.sv ----
// checker of the dual timer register readback and interrupt outputs
// assumes only the top module ports, one clock domain
`include "dt_timer_params.svh"
module dt_timer_monitor (
   // clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             rst_n_in,
   // register port
   input  wire logic [7:0]       sfr_addr_in,
   input  wire logic             sfr_wr_in,
   input  wire dt_pkg::dt_byte_t sfr_wdata_in,
   input  wire logic             sfr_bit_wr_in,
   input  wire logic [2:0]       sfr_bit_idx_in,
   input  wire logic             sfr_bit_val_in,
   input  wire dt_pkg::dt_byte_t sfr_rdata_out,
   // acknowledge and interrupts
   input  wire logic             t0_irq_ack_in,
   input  wire logic             t1_irq_ack_in,
   input  wire logic             t0_irq_out,
   input  wire logic             t1_irq_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import dt_pkg::*;
   logic [7:0] ctrl_reg, mode_reg, ien_reg;
   wire        at_ctrl  = sfr_addr_in == `DT_ADDR_CONTROL;
   wire        quiet    = !sfr_wr_in && !sfr_bit_wr_in;
   wire        mapped   = sfr_addr_in inside {[8'h88:8'h8E], 8'hA8};
   wire        clr_any  = sfr_wr_in | sfr_bit_wr_in | t0_irq_ack_in | t1_irq_ack_in;
   wire [7:0]  bit_mask = 8'h01 << sfr_bit_idx_in;
   wire [7:0]  bit_next = sfr_bit_val_in ? (ctrl_reg | bit_mask) : (ctrl_reg & ~bit_mask);
   wire [7:0]  ctrl_next = (sfr_wr_in && at_ctrl) ? sfr_wdata_in : (sfr_bit_wr_in && at_ctrl) ? bit_next : ctrl_reg;
   wire [7:0]  mode_next = (sfr_wr_in && sfr_addr_in == `DT_ADDR_MODE) ? sfr_wdata_in : mode_reg;
   wire [7:0]  ien_next = (sfr_wr_in && sfr_addr_in == `DT_ADDR_IRQ_ENABLE) ? sfr_wdata_in : ien_reg;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_reg <= `DT_RST_CONTROL;
         mode_reg <= 8'h00;
         ien_reg  <= 8'h00;
      end else begin
         ctrl_reg <= ctrl_next;
         mode_reg <= mode_next;
         ien_reg  <= ien_next;
      end
   end

   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   AST_UNMAPPED_READ: assert property (!mapped |=> sfr_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   AST_CTRL_READ: assert property (at_ctrl && quiet |=> (sfr_rdata_out & 8'h5F) == (ctrl_reg & 8'h5F))
      else $error("control readback wrong");
   AST_MODE_READ: assert property (sfr_addr_in == `DT_ADDR_MODE && quiet |=> sfr_rdata_out == mode_reg)
      else $error("mode readback wrong");
   AST_IEN_READ: assert property (sfr_addr_in == `DT_ADDR_IRQ_ENABLE && quiet |=> sfr_rdata_out == ien_reg)
      else $error("enable readback wrong");
   AST_T0_MASK: assert property (t0_irq_out |-> ien_reg[`DT_ET0_BIT])
      else $error("timer 0 request while masked");
   AST_T1_MASK: assert property (t1_irq_out |-> ien_reg[`DT_ET1_BIT])
      else $error("timer 1 request while masked");
   AST_T0_CLEAR: assert property ($fell(t0_irq_out) |-> $past(clr_any))
      else $error("timer 0 request dropped with no cause");
   AST_T1_CLEAR: assert property ($fell(t1_irq_out) |-> $past(clr_any))
      else $error("timer 1 request dropped with no cause");
endmodule

bind dt_timer dt_timer_monitor i_mon (.sys_clk_in, .rst_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in,
   .sfr_bit_wr_in, .sfr_bit_idx_in, .sfr_bit_val_in, .sfr_rdata_out, .t0_irq_ack_in, .t1_irq_ack_in,
   .t0_irq_out, .t1_irq_out);

// ---- verification/tb_top.sv ----
// testbench of the dual timer: registers, modes, gating, split, pins
// assumes the timer top with its checker bound
`include "dt_timer_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import dt_pkg::*;
   logic     sys_clk_in, rst_n_in, sfr_wr_in, sfr_bit_wr_in, sfr_bit_val_in;
   logic     ext_irq_in_a_n_in, ext_irq_in_b_n_in, t0_count_pin_in, t1_count_pin_in;
   logic     t0_irq_ack_in, t1_irq_ack_in, t0_irq_out, t1_irq_out, t1_baud_tick_out;
   logic [7:0] sfr_addr_in;
   logic [2:0] sfr_bit_idx_in;
   dt_byte_t sfr_wdata_in, sfr_rdata_out;
   int       fails, check_count, cyc;

   dt_timer i_dut (.sys_clk_in, .rst_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_bit_wr_in,
      .sfr_bit_idx_in, .sfr_bit_val_in, .sfr_rdata_out, .ext_irq_in_a_n_in, .ext_irq_in_b_n_in,
      .t0_count_pin_in, .t1_count_pin_in, .t0_irq_ack_in, .t1_irq_ack_in, .t0_irq_out, .t1_irq_out,
      .t1_baud_tick_out);

   initial begin
      sys_clk_in = 1'b0;
      forever #2 sys_clk_in = ~sys_clk_in;
   end

   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc > 4000) begin
         fails++;
         final_report;
      end
   end

   task automatic cmp8(input dt_byte_t got, input dt_byte_t exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      cmp8({7'h00, got}, {7'h00, exp});
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask

   task automatic wr(input logic [7:0] a, input dt_byte_t d);
      idle(1);
      #1 sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_wr_in = 1'b1;
      idle(1);
      #1 sfr_wr_in = 1'b0;
   endtask

   task automatic bw(input logic [2:0] i, input logic v);
      idle(1);
      #1 sfr_addr_in = `DT_ADDR_CONTROL;
      sfr_bit_idx_in = i;
      sfr_bit_val_in = v;
      sfr_bit_wr_in = 1'b1;
      idle(1);
      #1 sfr_bit_wr_in = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output dt_byte_t d);
      idle(1);
      #1 sfr_addr_in = a;
      idle(1);
      #1 d = sfr_rdata_out;
   endtask

   task automatic ack(input int i);
      idle(1);
      #1 {t1_irq_ack_in, t0_irq_ack_in} = i ? 2'b10 : 2'b01;
      idle(1);
      #1 {t1_irq_ack_in, t0_irq_ack_in} = 2'b00;
      cmp1(i ? t1_irq_out : t0_irq_out, 1'b0);
   endtask

   task automatic t_reset;
      logic [7:0] al [7] = '{8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'hA8};
      dt_byte_t d;
      rd(`DT_ADDR_CONTROL, d);
      cmp8(d, 8'h0A);
      foreach (al[k]) begin
         rd(al[k], d);
         cmp8(d, 8'h00);
      end
      wr(8'h90, 8'h5A);
      rd(8'h90, d);
      cmp8(d, 8'h00);
   endtask

   task automatic t_wrap(input int i, input logic [1:0] m, input dt_byte_t hi, lo, ehi, elo);
      logic [7:0] ah, al;
      dt_byte_t d;
      ah = i ? `DT_ADDR_T1_HIGH : `DT_ADDR_T0_HIGH;
      al = i ? `DT_ADDR_T1_LOW : `DT_ADDR_T0_LOW;
      wr(`DT_ADDR_MODE, {2'b00, m, 2'b00, m});
      wr(ah, hi);
      wr(al, lo);
      bw(i ? 3'd6 : 3'd4, 1'b1);
      bw(i ? 3'd6 : 3'd4, 1'b0);
      rd(ah, d);
      cmp8(d, ehi);
      rd(al, d);
      cmp8(d & (m == 2'd0 ? 8'h1F : 8'hFF), elo);
      rd(`DT_ADDR_CONTROL, d);
      cmp1(d[i ? 7 : 5], 1'b1);
      cmp1(i ? t1_irq_out : t0_irq_out, 1'b1);
      ack(i);
   endtask

   task automatic t_mask;
      wr(`DT_ADDR_IRQ_ENABLE, 8'h00);
      bw(3'd5, 1'b1);
      cmp1(t0_irq_out, 1'b0);
      wr(`DT_ADDR_IRQ_ENABLE, 8'h02);
      cmp1(t0_irq_out, 1'b1);
      bw(3'd5, 1'b0);
      cmp1(t0_irq_out, 1'b0);
      wr(`DT_ADDR_IRQ_ENABLE, 8'h0A);
   endtask

   task automatic t_gate;
      dt_byte_t d;
      wr(`DT_ADDR_MODE, 8'h09);
      wr(`DT_ADDR_T0_HIGH, 8'hFF);
      wr(`DT_ADDR_T0_LOW, 8'hFF);
      bw(3'd4, 1'b1);
      idle(8);
      rd(`DT_ADDR_T0_LOW, d);
      cmp8(d, 8'hFF);
      ext_irq_in_a_n_in = 1'b0;
      idle(8);
      cmp1(t0_irq_out, 1'b1);
      bw(3'd4, 1'b0);
      ext_irq_in_a_n_in = 1'b1;
      ack(0);
   endtask

   task automatic t_split;
      dt_byte_t d, e;
      logic seen;
      seen = 1'b0;
      wr(`DT_ADDR_T1_HIGH, 8'hFF);
      wr(`DT_ADDR_T1_LOW, 8'hF0);
      wr(`DT_ADDR_MODE, 8'h13);
      repeat (40) begin
         idle(1);
         #1 if (t1_baud_tick_out === 1'b1) seen = 1'b1;
      end
      cmp1(seen, 1'b1);
      cmp1(t1_irq_out, 1'b0);
      wr(`DT_ADDR_MODE, 8'h33);
      rd(`DT_ADDR_T1_LOW, d);
      idle(4);
      rd(`DT_ADDR_T1_LOW, e);
      cmp8(e, d);
      wr(`DT_ADDR_T0_HIGH, 8'hFF);
      bw(3'd6, 1'b1);
      idle(4);
      cmp1(t1_irq_out, 1'b1);
      bw(3'd6, 1'b0);
      ack(1);
   endtask

   task automatic pulse(input int p, input int n);
      repeat (n) begin
         idle(1);
         #1 {t1_count_pin_in, t0_count_pin_in} = p ? 2'b01 : 2'b10;
         idle(4);
         #1 {t1_count_pin_in, t0_count_pin_in} = 2'b11;
         idle(3);
      end
   endtask

   task automatic t_t1pin;
      dt_byte_t d;
      wr(`DT_ADDR_MODE, 8'hD1);
      wr(`DT_ADDR_T1_LOW, 8'h20);
      bw(3'd6, 1'b1);
      pulse(1, 2);
      #1 ext_irq_in_b_n_in = 1'b0;
      idle(4);
      pulse(1, 2);
      idle(4);
      bw(3'd6, 1'b0);
      ext_irq_in_b_n_in = 1'b1;
      rd(`DT_ADDR_T1_LOW, d);
      cmp8(d, 8'h22);
   endtask

   task automatic t_pin;
      dt_byte_t d;
      wr(`DT_ADDR_MODE, 8'h07);
      wr(`DT_ADDR_T0_LOW, 8'h10);
      bw(3'd4, 1'b1);
      pulse(0, 3);
      idle(4);
      bw(3'd4, 1'b0);
      rd(`DT_ADDR_T0_LOW, d);
      cmp8(d, 8'h13);
   endtask

   task automatic t_scale;
      dt_byte_t d, e;
      wr(`DT_ADDR_MODE, 8'h01);
      wr(`DT_ADDR_CLOCK_CTRL, 8'h01);
      wr(`DT_ADDR_T0_LOW, 8'h00);
      bw(3'd4, 1'b1);
      idle(40);
      bw(3'd4, 1'b0);
      rd(`DT_ADDR_T0_LOW, d);
      cmp1(d >= 8'h09 && d <= 8'h0C, 1'b1);
      idle(6);
      rd(`DT_ADDR_T0_LOW, e);
      cmp8(e, d);
   endtask

   initial begin
      {rst_n_in, sfr_wr_in, sfr_bit_wr_in, sfr_bit_val_in, t0_irq_ack_in, t1_irq_ack_in} = 6'h00;
      {ext_irq_in_a_n_in, ext_irq_in_b_n_in, t0_count_pin_in, t1_count_pin_in} = 4'hF;
      sfr_addr_in = 8'h00;
      sfr_bit_idx_in = 3'd0;
      sfr_wdata_in = 8'h00;
      idle(10);
      #1 rst_n_in = 1'b1;
      t_reset;
      wr(`DT_ADDR_CLOCK_CTRL, 8'h0C);
      wr(`DT_ADDR_IRQ_ENABLE, 8'h0A);
      for (int i = 0; i < 2; i++) begin
         t_wrap(i, 2'd0, 8'hFF, 8'h1F, 8'h00, 8'h01);
         t_wrap(i, 2'd1, 8'hFF, 8'hFF, 8'h00, 8'h01);
         t_wrap(i, 2'd2, 8'h80, 8'hFF, 8'h80, 8'h81);
      end
      t_mask;
      t_gate;
      t_split;
      t_pin;
      t_t1pin;
      t_scale;
      final_report;
   end
endmodule
